// >>> core/psc_ctrl.v
// pump mode and offset servo control: registers, pump mode, servo calibration
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "psc_consts.vh"

module psc_ctrl
#(
   parameter CAL_CYCLES = `PSC_CAL_CYCLES,
   parameter CNT_W = 21,
   parameter CORR_W = 8,
   parameter LVL_W = 8,
   parameter [6:0] GAIN_HI_THR = 7'h79,
   parameter [7:0] LVL_HI_THR = 8'h40
)
(
   input wire CLK_SYS_IN,
   input wire RESETN_IN,
   input wire [7:0] ADDR_IN,
   input wire [15:0] WDATA_IN,
   input wire WR_IN,
   input wire RD_IN,
   output reg [15:0] RDATA_OUT,
   input wire CORE_CLK_OK_IN,
   input wire [LVL_W-1:0] SIG_LEVEL_IN,
   input wire [3:0] OFFS_CMP_IN,
   output wire PUMP_RUN_OUT,
   output reg PUMP_HIGH_RAIL_OUT,
   output reg PUMP_CLK_OUT,
   output reg [6:0] LEFT_OUT_GAIN_OUT,
   output reg [6:0] RIGHT_OUT_GAIN_OUT,
   output reg LEFT_MUTE_OUT,
   output reg RIGHT_MUTE_OUT,
   output wire [3:0] SERVO_EN_OUT,
   output wire [3:0] CAL_BUSY_OUT,
   output wire [4*CORR_W-1:0] CORR_OUT
);

   // cycles per measurement step: eight steps make one calibration
   // the step count is cut to the counter width on purpose; CNT_W must hold it
   localparam integer STEP_INT = CAL_CYCLES / 8;
   localparam [CNT_W-1:0] STEP_CYCLES = STEP_INT[CNT_W-1:0];
   localparam [2:0] LAST_STEP = 3'h7;

   // =====================================================
   // reset release
   // =====================================================
   reg rst_meta_reg;
   reg rst_sync_reg;
   wire rst_n;

   // async assert, sync release, so no flop leaves reset on a split edge
   always @(posedge CLK_SYS_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   // every other flop uses rst_n, never the raw reset pin
   assign rst_n = rst_sync_reg;

   // =====================================================
   // register decode
   // =====================================================
   wire wr_lgain;
   wire wr_rgain;
   wire wr_mute;
   wire wr_in_servo;
   wire wr_out_servo;
   wire wr_pump_en;
   wire wr_pump_mode;
   wire wr_clk_cfg;
   wire commit;

   // one write strobe per register; unmapped offsets decode to nothing
   assign wr_lgain = WR_IN && (ADDR_IN == `PSC_OFS_LGAIN);
   assign wr_rgain = WR_IN && (ADDR_IN == `PSC_OFS_RGAIN);
   assign wr_mute = WR_IN && (ADDR_IN == `PSC_OFS_MUTE);
   assign wr_in_servo = WR_IN && (ADDR_IN == `PSC_OFS_IN_SERVO);
   assign wr_out_servo = WR_IN && (ADDR_IN == `PSC_OFS_OUT_SERVO);
   assign wr_pump_en = WR_IN && (ADDR_IN == `PSC_OFS_PUMP_EN);
   assign wr_pump_mode = WR_IN && (ADDR_IN == `PSC_OFS_PUMP_MODE);
   assign wr_clk_cfg = WR_IN && (ADDR_IN == `PSC_OFS_CLK_CFG);
   // either gain register's bit 8 applies both sides at once
   // commit bits are write-only and never stored, so they read back as zero
   assign commit = (wr_lgain || wr_rgain) && WDATA_IN[`PSC_BIT_COMMIT]; // [RL21] [RL5]

   // =====================================================
   // control registers
   // =====================================================
   reg [6:0] lgain_pend_reg;
   reg [6:0] rgain_pend_reg;
   reg lmute_pend_reg;
   reg rmute_pend_reg;
   reg pump_enable_reg;
   reg level_sel_reg;
   reg level_active_reg;
   reg [3:0] servo_en_reg;
   reg [2:0] rate_reg;
   reg [3:0] mclk_reg;

   // software-written state; pending gains only reach the outputs on commit
   always @(posedge CLK_SYS_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lgain_pend_reg <= `PSC_RST_GAIN;
         rgain_pend_reg <= `PSC_RST_GAIN;
         lmute_pend_reg <= 1'b0;
         rmute_pend_reg <= 1'b0;
         pump_enable_reg <= 1'b0;
         level_sel_reg <= 1'b0; // [RL9]
         level_active_reg <= 1'b0; // [RL9]
         servo_en_reg <= 4'h0;
         rate_reg <= `PSC_RST_RATE;
         mclk_reg <= `PSC_RST_MCLK;
         LEFT_OUT_GAIN_OUT <= `PSC_RST_GAIN;
         RIGHT_OUT_GAIN_OUT <= `PSC_RST_GAIN;
         LEFT_MUTE_OUT <= 1'b0;
         RIGHT_MUTE_OUT <= 1'b0;
      end
      else
      begin
         if (wr_lgain)
            lgain_pend_reg <= WDATA_IN[6:0];
         if (wr_rgain)
            rgain_pend_reg <= WDATA_IN[6:0];
         // mutes wait for a commit just as the gains do
         if (wr_mute)
         begin
            lmute_pend_reg <= WDATA_IN[`PSC_BIT_LMUTE];
            rmute_pend_reg <= WDATA_IN[`PSC_BIT_RMUTE];
         end
         if (wr_pump_en)
            pump_enable_reg <= WDATA_IN[`PSC_BIT_PUMP_EN]; // [RL1]
         if (wr_pump_mode)
            level_sel_reg <= WDATA_IN[`PSC_BIT_LEVEL_SEL];
         // selecting level tracking acts at once; falling back needs a commit
         if (wr_pump_mode && WDATA_IN[`PSC_BIT_LEVEL_SEL])
            level_active_reg <= 1'b1; // [RL6]
         else if (commit && !level_sel_reg)
            level_active_reg <= 1'b0; // [RL5]
         if (commit)
         begin
            // a commit written together with new gain takes that gain too
            LEFT_OUT_GAIN_OUT <= wr_lgain ? WDATA_IN[6:0] : lgain_pend_reg; // [RL21]
            RIGHT_OUT_GAIN_OUT <= wr_rgain ? WDATA_IN[6:0] : rgain_pend_reg; // [RL21]
            LEFT_MUTE_OUT <= lmute_pend_reg; // [RL21]
            RIGHT_MUTE_OUT <= rmute_pend_reg; // [RL21]
         end
         // enable bits only gate the path; they never start or stop a calibration
         if (wr_in_servo)
         begin
            servo_en_reg[3] <= WDATA_IN[`PSC_BIT_LEFT_EN]; // [RL12]
            servo_en_reg[2] <= WDATA_IN[`PSC_BIT_RIGHT_EN]; // [RL12]
         end
         if (wr_out_servo)
         begin
            servo_en_reg[1] <= WDATA_IN[`PSC_BIT_LEFT_EN]; // [RL12]
            servo_en_reg[0] <= WDATA_IN[`PSC_BIT_RIGHT_EN]; // [RL12]
         end
         // rate fields only feed the pump divider in this block
         if (wr_clk_cfg)
         begin
            rate_reg <= WDATA_IN[2:0];
            mclk_reg <= WDATA_IN[7:4];
         end
      end
   end
   assign SERVO_EN_OUT = servo_en_reg; // [RL11]

   // =====================================================
   // pump mode and clock
   // =====================================================
   // the rail choice lags gains and level by one cycle, which the rails tolerate
   wire pump_run;
   wire gain_high;
   wire lvl_high;
   reg [7:0] div_ratio;
   reg [7:0] div_cnt_reg;

   // without the core clock the pump cannot switch, so it counts as stopped
   assign pump_run = pump_enable_reg && CORE_CLK_OK_IN; // [RL1] [RL10]
   assign PUMP_RUN_OUT = pump_run;
   assign gain_high = (LEFT_OUT_GAIN_OUT >= GAIN_HI_THR) ||
                      (RIGHT_OUT_GAIN_OUT >= GAIN_HI_THR); // [RL3]
   assign lvl_high = (SIG_LEVEL_IN >= LVL_HI_THR); // [RL4]

   // divider from rate fields; low rails switch at half the rate
   // limitation: products above 127 wrap when doubled for the low rails
   always @*
   begin
      div_ratio = ({4'h0, mclk_reg} + 8'h01) * ({5'h00, rate_reg} + 8'h01); // [RL10]
      if (!PUMP_HIGH_RAIL_OUT)
         div_ratio = {div_ratio[6:0], 1'b1}; // [RL2]
   end

   // rail choice and switching clock, both idle while the pump is off
   always @(posedge CLK_SYS_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         PUMP_HIGH_RAIL_OUT <= 1'b0;
         PUMP_CLK_OUT <= 1'b0;
         div_cnt_reg <= 8'h00;
      end
      // the divider restarts from zero each time the pump starts
      else if (!pump_run)
      begin
         PUMP_HIGH_RAIL_OUT <= 1'b0; // [RL1]
         PUMP_CLK_OUT <= 1'b0; // [RL1]
         div_cnt_reg <= 8'h00;
      end
      else
      begin
         // level tracking narrows the gain decision by the live signal
         if (level_active_reg)
            PUMP_HIGH_RAIL_OUT <= gain_high && lvl_high; // [RL2] [RL4]
         else
            PUMP_HIGH_RAIL_OUT <= gain_high; // [RL2] [RL3]
         if (div_cnt_reg >= div_ratio)
         begin
            div_cnt_reg <= 8'h00;
            PUMP_CLK_OUT <= ~PUMP_CLK_OUT; // [RL10]
         end
         else
            div_cnt_reg <= div_cnt_reg + 8'h01;
      end
   end

   // =====================================================
   // servo channels: 0 out-R, 1 out-L, 2 in-R, 3 in-L
   // =====================================================
   wire [3:0] trig;
   wire [3:0] done;
   wire [3:0] busy;

   // write-1 trigger bits, which read back as zero
   // a trigger is taken only while the pump runs; otherwise it is lost
   assign trig[0] = wr_out_servo && WDATA_IN[`PSC_BIT_RIGHT_TRIG]; // [RL13]
   assign trig[1] = wr_out_servo && WDATA_IN[`PSC_BIT_LEFT_TRIG]; // [RL13]
   assign trig[2] = wr_in_servo && WDATA_IN[`PSC_BIT_RIGHT_TRIG]; // [RL13]
   assign trig[3] = wr_in_servo && WDATA_IN[`PSC_BIT_LEFT_TRIG]; // [RL13]
   assign CAL_BUSY_OUT = busy;

   // channel index order matches the status bits from bit 7 upward
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch = ch + 1)
      begin : g_servo
         reg busy_reg;
         reg done_reg;
         reg [2:0] step_reg;
         reg [CNT_W-1:0] cnt_reg;
         reg [CORR_W-1:0] corr_reg;
         reg [CORR_W-1:0] trial_reg;

         // each channel runs its own successive approximation in parallel
         always @(posedge CLK_SYS_IN or negedge rst_n)
         begin
            if (!rst_n)
            begin
               busy_reg <= 1'b0;
               done_reg <= 1'b0;
               step_reg <= 3'h0;
               cnt_reg <= {CNT_W{1'b0}};
               corr_reg <= `PSC_RST_CORR;
               trial_reg <= `PSC_RST_CORR;
            end
            else if (trig[ch] && pump_run)
            begin
               // a trigger during a run restarts it from the first step
               busy_reg <= 1'b1; // [RL13] [RL15] [RL20]
               done_reg <= 1'b0; // [RL22]
               step_reg <= 3'h0;
               cnt_reg <= {CNT_W{1'b0}};
               trial_reg <= `PSC_RST_CORR;
            end
            // losing the pump mid-run leaves done low, so no false finish is shown
            else if (busy_reg && !pump_run)
               busy_reg <= 1'b0; // [RL19] abandoned, old correction kept
            else if (busy_reg)
            begin
               // step boundary: judge the current bit, then try the next lower one
               if (cnt_reg >= STEP_CYCLES - 1'b1)
               begin
                  cnt_reg <= {CNT_W{1'b0}};
                  // comparator high means the trial overshoots: drop the bit
                  if (OFFS_CMP_IN[ch])
                     trial_reg[3'h7 - step_reg] <= 1'b0;
                  if (step_reg != LAST_STEP)
                  begin
                     trial_reg[3'h6 - step_reg] <= 1'b1;
                     step_reg <= step_reg + 3'h1;
                  end
                  else
                  begin
                     // the last bit is judged straight into the stored correction
                     busy_reg <= 1'b0;
                     done_reg <= 1'b1; // [RL16] [RL22]
                     corr_reg <= OFFS_CMP_IN[ch] ?
                        {trial_reg[7:1], 1'b0} : trial_reg; // [RL13]
                  end
               end
               else
                  cnt_reg <= cnt_reg + 1'b1; // [RL16]
            end
         end
         assign done[ch] = done_reg;
         assign busy[ch] = busy_reg;
         // correction stays put whatever the enable does
         assign CORR_OUT[ch*CORR_W +: CORR_W] = corr_reg; // [RL18]
      end
   endgenerate

   // =====================================================
   // read port
   // =====================================================
   reg [15:0] rd_next;

   // read mux; unmapped offsets and reserved bits return zero
   // status bits sit in one block so a single read shows all four channels
   always @*
   begin
      rd_next = 16'h0000;
      if (ADDR_IN == `PSC_OFS_LGAIN)
         rd_next[6:0] = lgain_pend_reg;
      else if (ADDR_IN == `PSC_OFS_RGAIN)
         rd_next[6:0] = rgain_pend_reg;
      else if (ADDR_IN == `PSC_OFS_MUTE)
      begin
         rd_next[`PSC_BIT_LMUTE] = lmute_pend_reg;
         rd_next[`PSC_BIT_RMUTE] = rmute_pend_reg;
      end
      else if (ADDR_IN == `PSC_OFS_IN_SERVO)
      begin
         rd_next[`PSC_BIT_LEFT_EN] = servo_en_reg[3];
         rd_next[`PSC_BIT_RIGHT_EN] = servo_en_reg[2];
      end
      else if (ADDR_IN == `PSC_OFS_OUT_SERVO)
      begin
         rd_next[`PSC_BIT_LEFT_EN] = servo_en_reg[1];
         rd_next[`PSC_BIT_RIGHT_EN] = servo_en_reg[0];
      end
      else if (ADDR_IN == `PSC_OFS_STATUS)
         rd_next[`PSC_BIT_DONE_LO +: 4] = done; // [RL14]
      else if (ADDR_IN == `PSC_OFS_PUMP_EN)
         rd_next[`PSC_BIT_PUMP_EN] = pump_enable_reg;
      else if (ADDR_IN == `PSC_OFS_PUMP_MODE)
         rd_next[`PSC_BIT_LEVEL_SEL] = level_sel_reg;
      else if (ADDR_IN == `PSC_OFS_CLK_CFG)
      begin
         rd_next[2:0] = rate_reg;
         rd_next[7:4] = mclk_reg;
      end
   end

   // read data stands only in the cycle after the strobe
   // zero outside the read cycle keeps a shared read bus quiet
   always @(posedge CLK_SYS_IN or negedge rst_n)
   begin
      if (!rst_n)
         RDATA_OUT <= 16'h0000;
      else if (RD_IN)
         RDATA_OUT <= rd_next;
      else
         RDATA_OUT <= 16'h0000;
   end

endmodule

// >>> core/psc_consts.vh
// constants for the pump mode and offset servo control block
// Contract
// [RL1] pump runs only while pump_enable (bit 0 of 48h) is set
// [RL2] while enabled, pump adapts rails and rate; select bit picks source
// [RL3] gain-register mode derives pump mode from committed left/right gains
// [RL4] level-tracking mode also uses the live DAC signal level
// [RL5] change to gain-register mode takes effect only on a commit write
// [RL6] change to level-tracking mode takes effect on the select write
// [RL7] software keeps gain-register mode while sidetone mixing is active
// [RL8] software keeps gain-register mode while playback enhancement is on
// [RL9] select bit resets to gain-register mode
// [RL10] pump needs core clock; divider ratio derived from rate fields
// [RL11] four independent servo channels: out left/right, in left/right
// [RL12] servo enables: bit 7 left, bit 3 right, in 3Dh and 3Ch
// [RL13] writing 1 to bit 6 or bit 2 starts that channel's calibration
// [RL14] done flags in 42h: bit 10 in-L, 9 in-R, 8 out-L, 7 out-R
// [RL15] calibration triggers on several channels run at the same time
// [RL16] calibration lasts about 24 ms then sets the done flag
// [RL17] software triggers output calibration only in a mute-and-short sequence
// [RL18] measured correction is kept even while the path is disabled
// [RL19] calibration only runs while pump enabled and clock present
// [RL20] correction updates may be written at any time, even during playback
// [RL21] commit bit 8 of either gain register applies both gains and mutes
// [RL22] done flag clears on a new trigger and sets when it finishes
`ifndef PSC_CONSTS_VH
`define PSC_CONSTS_VH
// register offsets
`define PSC_OFS_LGAIN 8'h02
`define PSC_OFS_RGAIN 8'h03
`define PSC_OFS_MUTE 8'h1A
`define PSC_OFS_IN_SERVO 8'h3C
`define PSC_OFS_OUT_SERVO 8'h3D
`define PSC_OFS_STATUS 8'h42
`define PSC_OFS_PUMP_EN 8'h48
`define PSC_OFS_PUMP_MODE 8'h52
`define PSC_OFS_CLK_CFG 8'h60
// field positions
`define PSC_BIT_COMMIT 8
`define PSC_BIT_LEFT_EN 7
`define PSC_BIT_LEFT_TRIG 6
`define PSC_BIT_RIGHT_EN 3
`define PSC_BIT_RIGHT_TRIG 2
`define PSC_BIT_DONE_LO 7
`define PSC_BIT_LMUTE 1
`define PSC_BIT_RMUTE 0
`define PSC_BIT_PUMP_EN 0
`define PSC_BIT_LEVEL_SEL 0
// reset values
`define PSC_RST_GAIN 7'h00
`define PSC_RST_CORR 8'h80
`define PSC_RST_RATE 3'h0
`define PSC_RST_MCLK 4'h0
// timing
`define PSC_CLK_MHZ 50
`define PSC_CAL_US 24000
`define PSC_CAL_CYCLES (`PSC_CAL_US * `PSC_CLK_MHZ)
`endif

// >>> verif/psc_ctrl_sva.sv
// checker for the pump mode and offset servo block, bound to its top ports
`timescale 1ns/1ps

module psc_ctrl_sva
#(
   parameter LVL_W = 8
)
(
   input wire CLK_SYS_IN,
   input wire RESETN_IN,
   input wire [7:0] ADDR_IN,
   input wire [15:0] WDATA_IN,
   input wire WR_IN,
   input wire RD_IN,
   input wire [15:0] RDATA_OUT,
   input wire CORE_CLK_OK_IN,
   input wire [LVL_W-1:0] SIG_LEVEL_IN,
   input wire PUMP_RUN_OUT,
   input wire PUMP_HIGH_RAIL_OUT,
   input wire PUMP_CLK_OUT,
   input wire [6:0] LEFT_OUT_GAIN_OUT,
   input wire [6:0] RIGHT_OUT_GAIN_OUT,
   input wire [3:0] SERVO_EN_OUT,
   input wire [3:0] CAL_BUSY_OUT
);
   // ==========================================
   // bus events
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RESETN_IN);
   wire commit_wr = WR_IN && (ADDR_IN == 8'h02 || ADDR_IN == 8'h03) && WDATA_IN[8];
   // ==========================================
   // properties
   a_pump_on: assert property (WR_IN && ADDR_IN == 8'h48 && WDATA_IN[0] && CORE_CLK_OK_IN
      |=> PUMP_RUN_OUT) else $error("pump did not start");
   a_pump_off: assert property (WR_IN && ADDR_IN == 8'h48 && !WDATA_IN[0] |=> !PUMP_RUN_OUT)
      else $error("pump still running");
   a_rail_off: assert property (!PUMP_RUN_OUT |=> !PUMP_HIGH_RAIL_OUT)
      else $error("high rail while stopped");
   a_clk_stop: assert property (!PUMP_RUN_OUT |=> !PUMP_CLK_OUT)
      else $error("pump clock while stopped");
   a_commit_left_gain: assert property (commit_wr && ADDR_IN == 8'h02
      |=> LEFT_OUT_GAIN_OUT == $past(WDATA_IN[6:0])) else $error("commit gain wrong");
   a_gain_hold: assert property (!commit_wr
      |=> $stable(LEFT_OUT_GAIN_OUT) && $stable(RIGHT_OUT_GAIN_OUT))
      else $error("gain moved without commit");
   a_level_low: assert property (WR_IN && ADDR_IN == 8'h52 && WDATA_IN[0] ##1
      SIG_LEVEL_IN < 8'h40 |=> !PUMP_HIGH_RAIL_OUT) else $error("level mode late");
   a_trig_busy: assert property (WR_IN && ADDR_IN == 8'h3D && WDATA_IN[6] && PUMP_RUN_OUT
      |=> CAL_BUSY_OUT[1]) else $error("calibration not started");
   a_trig_refused: assert property (WR_IN && ADDR_IN == 8'h3C && WDATA_IN[2] && !PUMP_RUN_OUT
      && !CAL_BUSY_OUT[2] |=> !CAL_BUSY_OUT[2]) else $error("calibration without pump");
   a_busy_min: assert property ($rose(CAL_BUSY_OUT[0]) |-> CAL_BUSY_OUT[0] [*8])
      else $error("calibration too short");
   a_servo_en: assert property (WR_IN && ADDR_IN == 8'h3C
      |=> SERVO_EN_OUT[3:2] == {$past(WDATA_IN[7]), $past(WDATA_IN[3])})
      else $error("input servo enables wrong");
   a_rd_idle: assert property (!RD_IN |=> RDATA_OUT == 16'h0000)
      else $error("read data outside read");
   // main scenarios reached
   c_cal: cover property ($rose(CAL_BUSY_OUT[3]));
   c_commit: cover property (commit_wr);
   c_level: cover property (WR_IN && ADDR_IN == 8'h52 && WDATA_IN[0]);
endmodule

bind psc_ctrl psc_ctrl_sva #(.LVL_W(LVL_W)) u_sva (.CLK_SYS_IN(CLK_SYS_IN),
   .RESETN_IN(RESETN_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
   .RDATA_OUT(RDATA_OUT), .CORE_CLK_OK_IN(CORE_CLK_OK_IN), .SIG_LEVEL_IN(SIG_LEVEL_IN),
   .PUMP_RUN_OUT(PUMP_RUN_OUT), .PUMP_HIGH_RAIL_OUT(PUMP_HIGH_RAIL_OUT),
   .PUMP_CLK_OUT(PUMP_CLK_OUT), .LEFT_OUT_GAIN_OUT(LEFT_OUT_GAIN_OUT),
   .RIGHT_OUT_GAIN_OUT(RIGHT_OUT_GAIN_OUT), .SERVO_EN_OUT(SERVO_EN_OUT),
   .CAL_BUSY_OUT(CAL_BUSY_OUT));

// >>> verif/psc_ctrl_tb.sv
// self-checking bench for the pump mode and offset servo block
`timescale 1ns/1ps

module psc_ctrl_tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic clk_ok = 1'b1;
   logic [7:0] lvl = 8'h00;
   logic [3:0] cmp = 4'h5;
   logic [15:0] rdata;
   logic run, rail, pclk, lm, rm, p0, seen;
   logic [6:0] lg, rg;
   logic [3:0] sen, busy;
   logic [31:0] corr;
   int n_mismatch = 0;
   int checks_done = 0;

   // short calibration so a full run takes 64 cycles
   psc_ctrl #(.CAL_CYCLES(64)) dut (.CLK_SYS_IN(clk), .RESETN_IN(rstn), .ADDR_IN(addr),
      .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata),
      .CORE_CLK_OK_IN(clk_ok), .SIG_LEVEL_IN(lvl), .OFFS_CMP_IN(cmp), .PUMP_RUN_OUT(run),
      .PUMP_HIGH_RAIL_OUT(rail), .PUMP_CLK_OUT(pclk), .LEFT_OUT_GAIN_OUT(lg),
      .RIGHT_OUT_GAIN_OUT(rg), .LEFT_MUTE_OUT(lm), .RIGHT_MUTE_OUT(rm), .SERVO_EN_OUT(sen),
      .CAL_BUSY_OUT(busy), .CORR_OUT(corr));

   // ==========================================
   // clock and watchdog
   initial
   begin
      forever #10 clk = ~clk;
   end
   initial
   begin
      #40000;
      n_mismatch++;
      end_sim;
   end

   // ==========================================
   // helpers
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // strobes are left high so back-to-back calls need no gap; idle drops them
   task wr(input logic [7:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      rd_s <= 1'b0;
      @(posedge clk);
   endtask
   task rd(input logic [7:0] a, input logic [15:0] exp, input string what);
      addr <= a;
      rd_s <= 1'b1;
      wr_s <= 1'b0;
      @(posedge clk);
      #1 chk(what, {16'h0000, exp}, {16'h0000, rdata});
   endtask
   task idle(input int n);
      wr_s <= 1'b0;
      rd_s <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ==========================================
   // test sequence
   initial
   begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      chk("corrections", 32'h80808080, corr);
      rd(8'h48, 16'h0000, "pump enable");
      rd(8'h52, 16'h0000, "level select");
      rd(8'h42, 16'h0000, "cal done");
      rd(8'h7F, 16'h0000, "unmapped");
      // pump start and its clock dependency
      wr(8'h60, 16'h0000);
      wr(8'h48, 16'h0001);
      idle(2);
      chk("pump run", 32'h1, {31'h0, run});
      chk("rail low gain", 32'h0, {31'h0, rail});
      p0 = pclk;
      seen = 1'b0;
      repeat (4)
      begin
         @(posedge clk);
         #1 seen = seen | (pclk !== p0);
      end
      chk("pump clock toggles", 32'h1, {31'h0, seen});
      clk_ok <= 1'b0;
      idle(2);
      chk("pump run no clock", 32'h0, {30'h0, run, pclk});
      clk_ok <= 1'b1;
      // gains only move on commit, and both move together
      wr(8'h02, 16'h007F);
      wr(8'h1A, 16'h0003);
      idle(2);
      chk("left gain held", 32'h0, {25'h0, lg});
      wr(8'h03, 16'h0179);
      idle(3);
      chk("gains", {16'h0, 7'h7F, 7'h79, 2'h3}, {16'h0, lg, rg, lm, rm});
      chk("rail gain mode", 32'h1, {31'h0, rail});
      // level tracking now; back to gain control waits for a commit
      lvl <= 8'h10;
      wr(8'h52, 16'h0001);
      idle(3);
      chk("rail level low", 32'h0, {31'h0, rail});
      lvl <= 8'h40;
      idle(3);
      chk("rail level high", 32'h1, {31'h0, rail});
      lvl <= 8'h10;
      wr(8'h52, 16'h0000);
      idle(3);
      chk("rail before commit", 32'h0, {31'h0, rail});
      wr(8'h02, 16'h017F);
      idle(3);
      chk("rail after commit", 32'h1, {31'h0, rail});
      // four channels triggered back to back run together
      wr(8'h3C, 16'h0044);
      wr(8'h3D, 16'h00CC);
      idle(1);
      #1 chk("busy", 32'hF, {28'h0, busy});
      chk("servo enables", 32'h3, {28'h0, sen});
      rd(8'h42, 16'h0000, "done while running");
      idle(55);
      rd(8'h42, 16'h0000, "done early");
      idle(10);
      rd(8'h42, 16'h0780, "done");
      chk("corrections", 32'hFF00FF00, corr);
      rd(8'h3D, 16'h0088, "servo register");
      // disabled paths keep their correction
      wr(8'h3D, 16'h0000);
      wr(8'h3C, 16'h0000);
      idle(2);
      chk("kept corrections", 32'hFF00FF00, corr);
      // retrigger clears one flag; pump loss aborts and refuses triggers
      cmp <= 4'h0;
      wr(8'h3D, 16'h0004);
      rd(8'h42, 16'h0700, "done after retrigger");
      idle(20);
      wr(8'h48, 16'h0000);
      wr(8'h3C, 16'h0004);
      idle(2);
      chk("busy after pump off", 32'h0, {28'h0, busy});
      rd(8'h42, 16'h0700, "done after abort");
      chk("corrections after abort", 32'hFF00FF00, corr);
      idle(2);
      end_sim;
   end
endmodule
